// [logic/cidep_defs.vh]
`ifndef CIDEP_DEFS_VH
`define CIDEP_DEFS_VH

// Register byte offsets
`define CIDEP_OFF_IDENTITY 12'hd00
`define CIDEP_OFF_STATE 12'hd04

// Identity field positions
`define CIDEP_ID_IMPL_HI 31
`define CIDEP_ID_IMPL_LO 24
`define CIDEP_ID_ARCH_HI 19
`define CIDEP_ID_ARCH_LO 16
`define CIDEP_ID_PART_HI 15
`define CIDEP_ID_PART_LO 4
`define CIDEP_ID_REV_HI 3
`define CIDEP_ID_REV_LO 0

// State register bit positions
`define CIDEP_BIT_NMI_SET 31
`define CIDEP_BIT_SVC_SET 28
`define CIDEP_BIT_SVC_CLR 27
`define CIDEP_BIT_TICK_SET 26
`define CIDEP_BIT_TICK_CLR 25
`define CIDEP_BIT_ANY_PEND 22

// Reset values
`define CIDEP_STATE_RESET 32'h00000000
`define CIDEP_RDATA_RESET 32'h00000000

`endif

// [logic/cidep_core.v]
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "cidep_defs.vh"

module cidep_core #(
  parameter [7:0] IMPL_CODE = 8'h5a,  // Arbitrary value
  parameter [3:0] ARCH_CODE = 4'h3,  // Arbitrary value
  parameter [11:0] PART_CODE = 12'h123,  // Arbitrary value
  parameter [3:0] REV_CODE = 4'h1  // Arbitrary value
) (
  input wire sys_clk,
  input wire reset,
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  input wire nmi_signal,
  input wire nmi_entry,
  input wire svc_entry,
  input wire tick_event,
  input wire tick_entry,
  input wire irq_pending_in,
  output reg nmi_pending,
  output reg svc_pending,
  output reg tick_pending
);

  function [31:0] identity_word;
    input dummy;
    begin
      identity_word = 32'h00000000;
      identity_word[`CIDEP_ID_IMPL_HI:`CIDEP_ID_IMPL_LO] = IMPL_CODE;
      identity_word[`CIDEP_ID_ARCH_HI:`CIDEP_ID_ARCH_LO] = ARCH_CODE;
      identity_word[`CIDEP_ID_PART_HI:`CIDEP_ID_PART_LO] = PART_CODE;
      identity_word[`CIDEP_ID_REV_HI:`CIDEP_ID_REV_LO] = REV_CODE;
    end
  endfunction

  localparam [11:0] ADDR_IDENTITY = `CIDEP_OFF_IDENTITY;
  localparam [11:0] ADDR_STATE = `CIDEP_OFF_STATE;
  localparam [1:0] SEL_NONE = 2'b00;
  localparam [1:0] SEL_IDENTITY = 2'b01;
  localparam [1:0] SEL_STATE = 2'b10;

  // True when the address equals the given register offset, with or without a strobe
  function addr_match;
    input [11:0] addr;
    input [11:0] offset;
    begin
      addr_match = (addr == offset);
    end
  endfunction

  // Next pending level; a set in the same cycle beats a clear
  function pend_update;
    input current;
    input clear;
    input set;
    begin
      if (set) begin
        pend_update = 1'b1;
      end else if (clear) begin
        pend_update = 1'b0;
      end else begin
        pend_update = current;
      end
    end
  endfunction

  // Read image of the state register
  function [31:0] state_image;
    input nmi;
    input svc;
    input tick;
    input irq;
    begin
      state_image = `CIDEP_STATE_RESET;
      state_image[`CIDEP_BIT_NMI_SET] = nmi;
      state_image[`CIDEP_BIT_SVC_SET] = svc;
      state_image[`CIDEP_BIT_TICK_SET] = tick;
      state_image[`CIDEP_BIT_ANY_PEND] = irq | svc | tick;
    end
  endfunction

  wire id_hit;
  wire state_hit;
  reg nmi_set_wr;
  reg svc_set_wr;
  reg svc_clr_wr;
  reg tick_set_wr;
  reg tick_clr_wr;
  reg nmi_set_req;
  reg nmi_clear_req;
  reg svc_set_req;
  reg svc_clear_req;
  reg tick_set_req;
  reg tick_clear_req;
  reg next_nmi_pending;
  reg next_svc_pending;
  reg next_tick_pending;
  reg [1:0] read_sel;
  reg [31:0] state_word;
  reg [31:0] next_reg_rdata;

  assign id_hit = addr_match(reg_addr, ADDR_IDENTITY);
  assign state_hit = addr_match(reg_addr, ADDR_STATE);

  // Only the state register takes writes
  always @* begin
    nmi_set_wr = 1'b0;
    svc_set_wr = 1'b0;
    svc_clr_wr = 1'b0;
    tick_set_wr = 1'b0;
    tick_clr_wr = 1'b0;
    if (reg_write && state_hit) begin
      nmi_set_wr = reg_wdata[`CIDEP_BIT_NMI_SET];
      svc_set_wr = reg_wdata[`CIDEP_BIT_SVC_SET];
      if (reg_wdata[`CIDEP_BIT_SVC_CLR] &&
          !reg_wdata[`CIDEP_BIT_SVC_SET]) begin
        svc_clr_wr = 1'b1;
      end
      tick_set_wr = reg_wdata[`CIDEP_BIT_TICK_SET];
      if (reg_wdata[`CIDEP_BIT_TICK_CLR] &&
          !reg_wdata[`CIDEP_BIT_TICK_SET]) begin
        tick_clr_wr = 1'b1;
      end
    end
  end

  // Requests from software and from the core
  always @* begin
    nmi_set_req = nmi_set_wr || nmi_signal;
    nmi_clear_req = nmi_entry;
    svc_set_req = svc_set_wr;
    svc_clear_req = svc_clr_wr || svc_entry;
    tick_set_req = tick_set_wr || tick_event;
    tick_clear_req = tick_clr_wr || tick_entry;
  end

  always @* begin
    next_nmi_pending = pend_update(nmi_pending, nmi_clear_req,
                                   nmi_set_req);
  end

  always @* begin
    next_svc_pending = pend_update(svc_pending, svc_clear_req,
                                   svc_set_req);
  end

  always @* begin
    next_tick_pending = pend_update(tick_pending, tick_clear_req,
                                    tick_set_req);
  end

  // Unmapped addresses answer zero
  always @* begin
    read_sel = SEL_NONE;
    if (reg_read && id_hit) begin
      read_sel = SEL_IDENTITY;
    end else if (reg_read && state_hit) begin
      read_sel = SEL_STATE;
    end
  end

  always @* begin
    state_word = state_image(nmi_pending, svc_pending, tick_pending,
                             irq_pending_in);
    case (read_sel)
      SEL_IDENTITY: begin
        next_reg_rdata = identity_word(1'b0);
      end
      SEL_STATE: begin
        next_reg_rdata = state_word;
      end
      default: begin
        next_reg_rdata = `CIDEP_RDATA_RESET;
      end
    endcase
  end

  // Straight from this flop to the core
  always @(posedge sys_clk) begin
    if (reset) begin
      nmi_pending <= 1'b0;
    end else begin
      nmi_pending <= next_nmi_pending;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      svc_pending <= 1'b0;
    end else begin
      svc_pending <= next_svc_pending;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      tick_pending <= 1'b0;
    end else begin
      tick_pending <= next_tick_pending;
    end
  end

  // Read data stands one cycle, zero otherwise
  always @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= `CIDEP_RDATA_RESET;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule
`default_nettype wire

// [verification/cidep_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module cidep_sva(input wire sys_clk,input wire reset,
  input wire [11:0] reg_addr,input wire [31:0] reg_wdata,
  input wire reg_write,input wire reg_read,input wire [31:0] reg_rdata,
  input wire nmi_signal,input wire nmi_entry,input wire tick_event,
  input wire nmi_pending,input wire svc_pending,input wire tick_pending);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire w=reg_write&&reg_addr==12'hd04;
  wire r=reg_read&&reg_addr==12'hd04;
  wire [31:0] d=reg_wdata;
  wire [31:0] q=reg_rdata;
  a_id_fixed: assert property (reg_read&&reg_addr==12'hd00
    |=> q==32'h5a031231) else $error("identity");
  a_nmi_set: assert property (w&&d[31] |=> nmi_pending)
    else $error("nmi set");
  a_nmi_read: assert property (r |=> q[31]==$past(nmi_pending))
    else $error("nmi read");
  a_nmi_clear: assert property (nmi_entry&&!nmi_signal&&!(w&&d[31])
    |=> !nmi_pending) else $error("nmi clear");
  a_nmi_quiet: assert property (!nmi_pending&&!nmi_signal&&!(w&&d[31])
    |=> !nmi_pending) else $error("nmi quiet");
  a_svc_set: assert property (w&&d[28] |=> svc_pending)
    else $error("svc set");
  a_svc_read: assert property (r |=> q[28]==$past(svc_pending))
    else $error("svc read");
  a_svc_clear: assert property (w&&d[28:27]==2'b01 |=> !svc_pending)
    else $error("svc clear");
  a_tick_clear: assert property (w&&d[26:25]==2'b01&&!tick_event
    |=> !tick_pending) else $error("tick clear");
  a_resv_zero: assert property (r |=> (q&32'h6bbfffff)==0)
    else $error("reserved");
endmodule
bind cidep_core cidep_sva chk(.*);
`default_nettype wire

// [verification/cidep_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cidep_model(input wire sys_clk,input wire en,
  input wire nmi_pending,output logic nmi_entry=0);
  // Handler entry one cycle after pending is seen
  always @(posedge sys_clk) nmi_entry<=en&&nmi_pending&&!nmi_entry;
endmodule
`default_nettype wire

// [verification/cidep_core_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module cidep_core_tb_top;
  logic sys_clk=0,reset=1,reg_write=0,reg_read=0,nmi_signal=0,en=0;
  logic svc_entry=0,tick_event=0,tick_entry=0,irq_pending_in=0;
  logic [11:0] reg_addr=0;
  logic [31:0] reg_wdata=0;
  wire [31:0] reg_rdata;
  wire nmi_entry,nmi_pending,svc_pending,tick_pending;
  int error_cnt=0,comparisons=0,cyc=0;
  // Address, write data, expected read-back
  logic [75:0] rows[9]='{{12'hd04,32'h0,32'h0},
    {12'hd00,32'hffffffff,32'h5a031231},{12'hd04,32'h10000000,32'h10400000},
    {12'hd04,32'h08000000,32'h0},{12'hd04,32'h04000000,32'h04400000},
    {12'hd04,32'h02000000,32'h0},{12'hd04,32'h80000000,32'h80000000},
    {12'hd04,32'h61bfffff,32'h80000000},{12'he00,32'hffffffff,32'h0}};
  cidep_core dut(.*);
  cidep_model m(.sys_clk(sys_clk),.en(en),.nmi_pending(nmi_pending),
    .nmi_entry(nmi_entry));
  initial forever #4 sys_clk=~sys_clk;
  always @(posedge sys_clk) if(++cyc==1000) begin
    error_cnt++;
    tally_and_finish;
  end
  task wr(input [11:0] a,input [31:0] v);
    @(posedge sys_clk) begin reg_write<=1; reg_addr<=a; reg_wdata<=v; end
    @(posedge sys_clk) reg_write<=0;
  endtask
  task rd(input [11:0] a,input [31:0] e);
    @(posedge sys_clk) begin reg_read<=1; reg_addr<=a; end
    @(posedge sys_clk) reg_read<=0;
    @(negedge sys_clk) comparisons++;
    if(reg_rdata!==e) begin
      error_cnt++;
      $display("mismatch reg_rdata exp %h seen %h",e,reg_rdata);
    end
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d",comparisons,error_cnt);
    if(error_cnt==0&&comparisons>0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat(8) @(posedge sys_clk);
    reset<=0;
    foreach(rows[i]) begin
      wr(rows[i][75:64],rows[i][63:32]);
      rd(rows[i][75:64],rows[i][31:0]);
    end
    $display("table test done");
    @(posedge sys_clk) en<=1;
    repeat(3) @(posedge sys_clk);
    rd(12'hd04,32'h0);
    @(posedge sys_clk) begin en<=0; nmi_signal<=1; end
    @(posedge sys_clk) nmi_signal<=0;
    rd(12'hd04,32'h80000000);
    @(posedge sys_clk) irq_pending_in<=1;
    rd(12'hd04,32'h80400000);
    @(posedge sys_clk) begin
      irq_pending_in<=0; tick_event<=1; reg_write<=1;
      reg_addr<=12'hd04; reg_wdata<=32'h02000000;
    end
    @(posedge sys_clk) begin tick_event<=0; reg_write<=0; end
    rd(12'hd04,32'h84400000);
    wr(12'hd04,32'h10000000);
    @(posedge sys_clk) begin svc_entry<=1; tick_entry<=1; end
    @(posedge sys_clk) begin svc_entry<=0; tick_entry<=0; end
    rd(12'hd04,32'h80000000);
    $display("handler test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
